// [bench/smg_gen_model.sv]
/*
 * Waveform engine model: one point per clock, looping over a segment.
 * Assumes seg is at least 16 and a multiple of 16.
 */
`timescale 1ns/1ps
module smg_gen_model
   import smg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // settings
   input wire smg_wave_e wave,
   input wire logic [19:0] seg,
   // engine status
   output smg_gen_s gen
);
   logic [19:0] idx_reg;

   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         idx_reg <= 20'h0_0000;
      else if (idx_reg >= seg - 20'h0_0001)
         idx_reg <= 20'h0_0000;
      else
         idx_reg <= idx_reg + 20'h0_0001;

   always_comb
   begin
      gen = '0;
      gen.wave = wave;
      gen.run = 1'b1;
      gen.pt_index = idx_reg;
      gen.seg_len = seg;
      gen.seq_start = idx_reg == 20'h0_0000;
      gen.seq_end = idx_reg == seg - 20'h0_0001;
      gen.seg_first = gen.seq_start;
      gen.trig_align = gen.seq_start;
      gen.level_pos = idx_reg < (seg >> 1);
      gen.marker = idx_reg[3];
      gen.int_trig = idx_reg[2];
   end
endmodule // smg_gen_model

// [bench/smg_monitor.sv]
/*
 * Checker of the sync and trigger outputs, watching top ports only.
 * Assumes the register map and output latencies of smg_pkg and smg_top.
 */
`timescale 1ns/1ps
module smg_monitor
   import smg_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // register port
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   // engine, pin and outputs
   input wire smg_gen_s GEN,
   input wire logic EXT_TRIG,
   input wire logic SYNC_OUT,
   input wire logic TRIG_OUT
);
   logic en_reg;
   logic [2:0] src_reg;
   logic [1:0] trg_reg;
   logic [19:0] pos_reg;
   logic loopw;
   logic hit;
   logic bitw;

   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);

   // ***********************************************************
   // shadow of written settings
   // ***********************************************************
   always_ff @(posedge CLK or negedge NRST)
      if (!NRST)
      begin
         en_reg <= 1'b0;
         src_reg <= 3'h0;
         trg_reg <= 2'h0;
         pos_reg <= 20'h0_0000;
      end
      else if (WR && ADDR == A_CTRL)
      begin
         en_reg <= WDATA[0];
         if (WDATA[6:4] <= 3'h4)
            src_reg <= WDATA[6:4];
      end
      else if (WR && ADDR == A_TRIG)
         trg_reg <= WDATA[1:0];
      else if (WR && ADDR == A_POS)
         pos_reg <= (WDATA[19:0] > POS_MAX ? POS_MAX : WDATA[19:0]) & 20'hF_FFFC;

   assign loopw = GEN.wave inside {WV_SEQ, WV_BURST};
   assign hit = GEN.run && GEN.pt_index == pos_reg;
   assign bitw = en_reg && src_reg == SRC_BIT && GEN.wave == WV_STD;

   // ***********************************************************
   // assertions
   // ***********************************************************
   AST_EN_OFF: assert property (!en_reg |=> !SYNC_OUT)
      else $error("sync output high while disabled");
   AST_BIT_W: assert property (bitw && hit ##1 bitw[*5]
      |-> $past(SYNC_OUT, 3) && $past(SYNC_OUT, 2) && $past(SYNC_OUT)
      && SYNC_OUT ##1 !SYNC_OUT)
      else $error("bit pulse not four clocks at position");
   AST_TRIG_BIT: assert property (trg_reg == TRG_BIT && hit
      ##1 trg_reg == TRG_BIT |-> TRIG_OUT ##1 !TRIG_OUT)
      else $error("bit trigger not one clock at position");
   AST_TRIG_INT: assert property (trg_reg == TRG_INT
      |=> TRIG_OUT == $past(GEN.int_trig))
      else $error("trigger does not follow internal source");
   AST_TRIG_EXT: assert property (trg_reg == TRG_EXT
      |=> TRIG_OUT == $past(EXT_TRIG, 3))
      else $error("trigger does not follow pin");
   AST_ZERO: assert property (en_reg && src_reg == SRC_ZERO && !loopw
      |=> SYNC_OUT == $past(GEN.level_pos))
      else $error("zero mode does not follow level sign");
   AST_MOD: assert property (en_reg && src_reg == SRC_BIT
      && GEN.wave == WV_MOD |=> SYNC_OUT == $past(GEN.marker))
      else $error("marker not passed in modulated mode");
   AST_LOOP_FALL: assert property (en_reg && loopw && GEN.seq_end
      |-> ##2 !SYNC_OUT)
      else $error("loop pulse not ended at sequence end");
   AST_LOOP_RISE: assert property (en_reg && loopw && GEN.seq_start
      && pos_reg == 20'h0_0000 ##1 en_reg && loopw |=> SYNC_OUT)
      else $error("loop pulse not started at sequence start");

   cover property (en_reg && loopw && GEN.seq_end);
   cover property (TRIG_OUT && trg_reg == TRG_EXT);
   cover property (SYNC_OUT && src_reg == SRC_PULSE);
endmodule // smg_monitor

bind smg_top smg_monitor u_mon (.CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
   .GEN, .EXT_TRIG, .SYNC_OUT, .TRIG_OUT);

// [bench/test_sync_marker_output_gen.sv]
/*
 * Self-checking bench of smg_top with the engine model and the checker.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
module test_sync_marker_output_gen;
   import smg_pkg::*;
   logic clk, nrst, wr, rd, ext, sync_o, trig_o;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic [19:0] seg;
   smg_gen_s gen;
   smg_wave_e wave;
   int n_fail, samples_checked, ns, nt, sg, p, w;

   smg_gen_model u_gen (.clk(clk), .nrst(nrst), .wave(wave), .seg(seg),
      .gen(gen));
   smg_top u_dut (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .GEN(gen), .EXT_TRIG(ext),
      .SYNC_OUT(sync_o), .TRIG_OUT(trig_o));

   always #2.5 clk = ~clk;

   // ***********************************************************
   // tasks and expectations
   // ***********************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd32(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, e);
   endtask

   task automatic setm(input int s, input int en, input int t,
      input smg_wave_e wv);
      wr32(A_CTRL, 32'((s << 4) | en));
      wr32(A_TRIG, 32'(t));
      wave <= wv;
   endtask

   // high clocks of both outputs over a window
   task automatic meas(input int st, input int win);
      ns = 0;
      nt = 0;
      repeat (st) @(posedge clk);
      repeat (win)
      begin
         @(negedge clk);
         ns += int'(sync_o === 1'b1);
         nt += int'(trig_o === 1'b1);
      end
   endtask

   function automatic logic [31:0] name_of(input int s);
      logic [31:0] t [5] = '{NAME_BIT, NAME_LOOP, NAME_ALIGN, NAME_PULSE,
         NAME_ZERO};
      return t[s];
   endfunction

   function automatic int wexp(input int v, input int sl);
      int lim;
      lim = (sl - 8) & ~3;
      v = ((v > 60) ? 60 : v) & ~3;
      v = (v > lim) ? lim : v;
      return (v < 4) ? 4 : v;
   endfunction

   task automatic test_done();
      $display("compares %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ***********************************************************
   // sequence
   // ***********************************************************
   initial
   begin
      clk = 1'b0;
      nrst = 1'b0;
      {wr, rd, ext} = 3'h0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      wave = WV_STD;
      seg = 20'h0_0040;
      n_fail = 0;
      samples_checked = 0;
      void'($urandom(65576));
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd32(A_CTRL, 32'h0000_0000);
      rd32(A_NAME, NAME_BIT);
      rd32(8'h20, 32'h0000_0000);
      for (int i = 0; i < 8; i++)
      begin
         wr32(A_CTRL, 32'((i << 4) | 1));
         rd32(A_NAME, name_of(i < 5 ? i : 4));
      end
      wr32(A_POS, 32'h000F_FFFF);
      rd32(A_POS, 32'h000F_423C);
      wr32(A_WID, 32'h0000_0002);
      rd32(A_WID, 32'h0000_0004);
      $display("test names done");
      for (int k = 0; k < 3; k++)
      begin
         sg = (k == 0) ? 32 : 32 * (2 + $urandom % 3);
         p = (k == 0) ? 0 : 4 * ($urandom % (sg / 8));
         w = (k == 0) ? 60 : $urandom % 64;
         seg <= 20'(sg);
         wr32(A_POS, 32'(p));
         wr32(A_WID, 32'(w));
         setm(SRC_BIT, 1, TRG_BIT, WV_STD);
         meas(sg, 2 * sg);
         check(ns, 8);
         check(nt, 2);
         setm(SRC_ALIGNED_BIT, 1, TRG_INT, WV_STD);
         meas(sg, 2 * sg);
         check(ns, 8);
         check(nt, sg);
         setm(SRC_BIT, 1, TRG_INT, WV_MOD);
         meas(sg, 2 * sg);
         check(ns, sg);
         setm(SRC_ZERO, 1, TRG_BIT, WV_STD);
         meas(sg, 2 * sg);
         check(ns, sg);
         setm(SRC_ZERO, 0, TRG_BIT, WV_STD);
         meas(sg, 2 * sg);
         check(ns, 0);
         setm(SRC_BIT, 1, TRG_LOOP_DONE, WV_SEQ);
         // skip the edge that still used the old trigger source
         meas(1, 3 * sg);
         check(nt, 1);
         meas(0, 2 * sg);
         check(ns, 2 * (sg - 1 - p));
         rd32(A_NAME, NAME_LOOP);
         setm(SRC_PULSE, 1, TRG_BIT, WV_BURST);
         meas(sg, 2 * sg);
         check(ns, 2 * (sg - 1 - p));
         setm(SRC_PULSE, 1, TRG_BIT, WV_ARB);
         meas(sg, 2 * sg);
         check(ns, 2 * wexp(w, sg));
         setm(SRC_PULSE, 1, TRG_BIT, WV_STD);
         meas(sg, 2 * sg);
         check(ns, 8);
         $display("test round %0d done", k);
      end
      wr32(A_TRIG, 32'(TRG_EXT));
      fork
         meas(1, 20);
         begin
            ext <= 1'b1;
            repeat (10) @(posedge clk);
            ext <= 1'b0;
         end
      join
      check(nt, 10);
      $display("test pin trigger done");
      test_done();
   end

   initial
   begin
      #(60000 * 5);
      n_fail++;
      test_done();
   end
endmodule // test_sync_marker_output_gen

// [verilog/smg_pkg.sv]
/*
 * Package of the sync and marker output generator: register offsets,
 * field positions, reset values, limits, mode codes and the carrier
 * struct for the waveform engine's status.
 * Assumes the waveform engine advances one point per CLK while running.
 */
package smg_pkg;

   // ***********************************************************
   // register map
   // ***********************************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_POS = 8'h04;
   localparam logic [7:0] A_WID = 8'h08;
   localparam logic [7:0] A_TRIG = 8'h0C;
   localparam logic [7:0] A_NAME = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;

   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_SRC_LSB = 4;
   localparam int STAT_SYNC_BIT = 0;
   localparam int STAT_TRIG_BIT = 1;
   localparam int STAT_SRC_LSB = 4;

   // ***********************************************************
   // limits and reset values
   // ***********************************************************
   localparam int PT_W = 20;
   localparam int WID_W = 6;
   localparam logic [19:0] POS_MAX = 20'hF_423F;
   localparam logic [19:0] POS_RST = 20'h0_0000;
   localparam logic [5:0] WID_MIN = 6'h04;
   localparam logic [5:0] WID_MAX = 6'h3C;
   localparam logic [5:0] WID_RST = 6'h04;
   localparam logic [5:0] BIT_WID = 6'h04;
   localparam logic [19:0] SEG_MARGIN = 20'h0_0008;
   localparam logic [1:0] STEP_MASK = 2'h3;

   // ***********************************************************
   // modes
   // ***********************************************************
   typedef enum logic [2:0] {
      SRC_BIT = 3'h0,
      SRC_LOOP_DONE = 3'h1,
      SRC_ALIGNED_BIT = 3'h2,
      SRC_PULSE = 3'h3,
      SRC_ZERO = 3'h4
   } smg_src_e;

   typedef enum logic [1:0] {
      TRG_BIT = 2'h0,
      TRG_LOOP_DONE = 2'h1,
      TRG_INT = 2'h2,
      TRG_EXT = 2'h3
   } smg_trg_e;

   typedef enum logic [2:0] {
      WV_STD = 3'h0,
      WV_ARB = 3'h1,
      WV_MOD = 3'h2,
      WV_SEQ = 3'h3,
      WV_BURST = 3'h4
   } smg_wave_e;

   // ascii names of the sync conditions, space padded
   localparam logic [31:0] NAME_BIT = 32'h4249_5420;
   localparam logic [31:0] NAME_LOOP = 32'h4C43_4F4D;
   localparam logic [31:0] NAME_ALIGN = 32'h5353_594E;
   localparam logic [31:0] NAME_PULSE = 32'h5055_4C53;
   localparam logic [31:0] NAME_ZERO = 32'h5A45_524F;

   // ***********************************************************
   // waveform engine status, same clock domain
   // ***********************************************************
   typedef struct packed {
      smg_wave_e wave;
      logic run;
      logic [19:0] pt_index;
      logic [19:0] seg_len;
      logic seq_start;
      logic seq_end;
      logic seg_first;
      logic level_pos;
      logic trig_align;
      logic marker;
      logic int_trig;
   } smg_gen_s;

endpackage

// [verilog/smg_pulse.sv]
/*
 * Pulse stretcher: a start strobe opens a pulse that lasts width clocks.
 * Assumes width is at least one; a new start restarts the pulse.
 */
`timescale 1ns/1ps
module smg_pulse
   import smg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // control
   input wire logic start,
   input wire logic [WID_W-1:0] width,
   // pulse
   output logic active
);

   logic [WID_W-1:0] cnt_reg;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cnt_reg <= '0;
      else if (start)
         cnt_reg <= width;
      else if (cnt_reg != '0)
         cnt_reg <= cnt_reg - 1'b1;
   end

   assign active = (cnt_reg != '0);

endmodule // smg_pulse

// [verilog/smg_sync2.sv]
/*
 * Two flip-flop synchroniser for one level from outside the clock domain.
 * Assumes the input is slow against CLK.
 */
`timescale 1ns/1ps
module smg_sync2
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // level
   input wire logic d,
   output logic q
);

   logic meta_reg;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule // smg_sync2

// [verilog/smg_top.sv]
/*
 * Sync and marker output generator with backplane trigger source select.
 * Registers on a plain port; read data one cycle after the read strobe.
 * Assumes GEN comes from the waveform engine on CLK, one point per clock
 * while running; EXT_TRIG is a pin and is synchronised here.
 */
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
module smg_top
   import smg_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // register port
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // waveform engine
   input wire smg_gen_s GEN,
   // trigger input pin
   input wire logic EXT_TRIG,
   // outputs
   output logic SYNC_OUT,
   output logic TRIG_OUT
);

   // ***********************************************************
   // declarations
   // ***********************************************************
   logic en_reg;
   smg_src_e src_reg;
   logic [PT_W-1:0] pos_reg;
   logic [WID_W-1:0] wid_reg;
   smg_trg_e trg_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic loop_reg;
   logic fired_reg;
   logic [PT_W-1:0] align_cnt_reg;
   logic sync_reg;
   logic sync_next;
   logic trig_reg;
   logic trig_next;
   smg_src_e eff_src;
   logic [WID_W-1:0] wid_eff;
   logic [PT_W-1:0] seg_lim;
   logic [WID_W-1:0] pos_wid;
   logic [PT_W-1:0] pos_wdata;
   logic [WID_W-1:0] wid_wdata;
   logic pos_hit;
   logic align_hit;
   logic pulse_start;
   logic pulse_act;
   logic ext_sync;
   logic [31:0] name_word;
   logic [31:0] stat_word;

   // ***********************************************************
   // helpers
   // ***********************************************************
   smg_sync2 u_ext_sync
   (
      .clk(CLK),
      .nrst(NRST),
      .d(EXT_TRIG),
      .q(ext_sync)
   );

   smg_pulse u_pulse
   (
      .clk(CLK),
      .nrst(NRST),
      .start(pulse_start),
      .width(wid_eff),
      .active(pulse_act)
   );

   // ***********************************************************
   // register writes
   // ***********************************************************
   always_comb
   begin
      // clamp and snap to four-point steps
      pos_wdata = WDATA[PT_W-1:0];
      if (pos_wdata > POS_MAX)
         pos_wdata = POS_MAX;
      pos_wdata[1:0] = ~STEP_MASK & pos_wdata[1:0];
      wid_wdata = WDATA[WID_W-1:0];
      if (WDATA[31:WID_W] != '0 || wid_wdata > WID_MAX)
         wid_wdata = WID_MAX;
      wid_wdata[1:0] = ~STEP_MASK & wid_wdata[1:0];
      if (wid_wdata < WID_MIN)
         wid_wdata = WID_MIN;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         en_reg <= 1'b0;
         src_reg <= SRC_BIT;
      end
      else if (WR && ADDR == A_CTRL)
      begin
         en_reg <= WDATA[CTRL_EN_BIT];
         case (WDATA[CTRL_SRC_LSB +: 3])
            SRC_BIT,
            SRC_LOOP_DONE,
            SRC_ALIGNED_BIT,
            SRC_PULSE,
            SRC_ZERO:
               src_reg <= smg_src_e'(WDATA[CTRL_SRC_LSB +: 3]);
            default:
               src_reg <= src_reg;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         pos_reg <= POS_RST;
      else if (WR && ADDR == A_POS)
         pos_reg <= pos_wdata;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         wid_reg <= WID_RST;
      else if (WR && ADDR == A_WID)
         wid_reg <= wid_wdata;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         trg_reg <= TRG_BIT;
      else if (WR && ADDR == A_TRIG)
         trg_reg <= smg_trg_e'(WDATA[1:0]);
   end

   // ***********************************************************
   // effective mode and width
   // ***********************************************************
   always_comb
   begin
      if (GEN.wave == WV_SEQ || GEN.wave == WV_BURST)
         eff_src = SRC_LOOP_DONE;
      else
         eff_src = src_reg;
   end

   always_comb
   begin
      // longest pulse is segment length less eight, in four-point steps
      seg_lim = GEN.seg_len - SEG_MARGIN;
      pos_wid = wid_reg;
      if (GEN.seg_len < SEG_MARGIN + {14'h0000, WID_MIN})
         pos_wid = WID_MIN;
      else if ({14'h0000, wid_reg} > seg_lim)
         pos_wid = {seg_lim[WID_W-1:2], 2'b00};
      if (eff_src == SRC_PULSE && GEN.wave == WV_ARB)
         wid_eff = pos_wid;
      else
         wid_eff = BIT_WID;
   end

   // ***********************************************************
   // position match
   // ***********************************************************
   assign pos_hit = GEN.run && GEN.pt_index == pos_reg;
   assign align_hit = GEN.run && align_cnt_reg == pos_reg;

   // point count restarted by the triggered signal, free of trigger jitter
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         align_cnt_reg <= '0;
      else if (GEN.trig_align)
         align_cnt_reg <= '0;
      else if (GEN.run && align_cnt_reg != POS_MAX)
         align_cnt_reg <= align_cnt_reg + 1'b1;
   end

   always_comb
   begin
      if (eff_src == SRC_ALIGNED_BIT)
         pulse_start = align_hit;
      else
         pulse_start = pos_hit;
   end

   // ***********************************************************
   // loop done level
   // ***********************************************************
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         loop_reg <= 1'b0;
      else if (GEN.seq_end)
         loop_reg <= 1'b0;
      else if (GEN.seq_start && pos_reg == POS_RST)
         loop_reg <= 1'b1;
      else if (pos_hit && pos_reg != POS_RST)
         loop_reg <= 1'b1;
   end

   // ***********************************************************
   // sync output
   // ***********************************************************
   always_comb
   begin
      case (eff_src)
         SRC_BIT:
            if (GEN.wave == WV_MOD)
               sync_next = GEN.marker;
            else
               sync_next = pulse_act;
         SRC_LOOP_DONE:
            sync_next = loop_reg;
         SRC_ALIGNED_BIT:
            sync_next = pulse_act;
         SRC_PULSE:
            sync_next = pulse_act;
         SRC_ZERO:
            sync_next = GEN.level_pos;
         default:
            sync_next = 1'b0;
      endcase
      sync_next = sync_next & en_reg;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         sync_reg <= 1'b0;
      else
         sync_reg <= sync_next;
   end

   // ***********************************************************
   // trigger output
   // ***********************************************************
   // one loop done trigger per arming; rewriting the source re-arms it unless it fires in that clock
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         fired_reg <= 1'b0;
      else if (trig_next && trg_reg == TRG_LOOP_DONE)
         fired_reg <= 1'b1;
      else if (WR && ADDR == A_TRIG)
         fired_reg <= 1'b0;
   end

   always_comb
   begin
      case (trg_reg)
         TRG_BIT:
            trig_next = pos_hit;
         TRG_LOOP_DONE:
            trig_next = GEN.seg_first && GEN.wave == WV_SEQ && !fired_reg;
         TRG_INT:
            trig_next = GEN.int_trig;
         TRG_EXT:
            trig_next = ext_sync;
         default:
            trig_next = 1'b0;
      endcase
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         trig_reg <= 1'b0;
      else
         trig_reg <= trig_next;
   end

   // ***********************************************************
   // register reads
   // ***********************************************************
   always_comb
   begin
      case (eff_src)
         SRC_BIT:
            name_word = NAME_BIT;
         SRC_LOOP_DONE:
            name_word = NAME_LOOP;
         SRC_ALIGNED_BIT:
            name_word = NAME_ALIGN;
         SRC_PULSE:
            name_word = NAME_PULSE;
         SRC_ZERO:
            name_word = NAME_ZERO;
         default:
            name_word = '0;
      endcase
      stat_word = '0;
      stat_word[STAT_SYNC_BIT] = sync_reg;
      stat_word[STAT_TRIG_BIT] = trig_reg;
      stat_word[STAT_SRC_LSB +: 3] = eff_src;
   end

   always_comb
   begin
      rdata_next = '0;
      if (RD)
      begin
         case (ADDR)
            A_CTRL:
            begin
               rdata_next[CTRL_EN_BIT] = en_reg;
               rdata_next[CTRL_SRC_LSB +: 3] = src_reg;
            end
            A_POS:
               rdata_next[PT_W-1:0] = pos_reg;
            A_WID:
               rdata_next[WID_W-1:0] = wid_reg;
            A_TRIG:
               rdata_next[1:0] = trg_reg;
            A_NAME:
               rdata_next = name_word;
            A_STAT:
               rdata_next = stat_word;
            default:
               rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         rdata_reg <= '0;
      else
         rdata_reg <= rdata_next;
   end

   assign RDATA = rdata_reg;
   assign SYNC_OUT = sync_reg;
   assign TRIG_OUT = trig_reg;

endmodule // smg_top
